// File: hdl/cfg_pkg.sv
// Constants, field layouts and carriers of the gain and chop/detect registers
`default_nettype none
package cfg_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned REG_IDX_GAIN = 5;
  localparam int unsigned REG_IDX_CFG = 6;
  localparam logic [11:0] ADDR_GAIN = 12'(4 * REG_IDX_GAIN);
  localparam logic [11:0] ADDR_CFG = 12'(4 * REG_IDX_CFG);
  // Reset images
  localparam logic [15:0] GAIN_RESET = 16'h0000;
  localparam logic [15:0] CFG_RESET = 16'h0600;
  // Field positions
  localparam int unsigned GAIN_CH5_LSB = 4;
  localparam int unsigned GAIN_CH4_LSB = 0;
  localparam int unsigned CHOP_DLY_LSB = 9;
  localparam int unsigned CHOP_EN_BIT = 8;
  localparam int unsigned DET_ALL_BIT = 7;
  localparam int unsigned DET_NUM_LSB = 4;
  localparam int unsigned DET_LEN_LSB = 1;
  localparam int unsigned DET_EN_BIT = 0;
  // Timer width; holds the longest settle delay of 65536 periods
  localparam int unsigned CHOP_CNT_W = 17;

  typedef struct packed {
    logic [2:0] amp_gain_code_ch5;
    logic [2:0] amp_gain_code_ch4;
  } gain_cfg_t;

  typedef struct packed {
    logic [3:0] chop_settle_delay;
    logic chop_enable;
  } chop_cfg_t;

  typedef struct packed {
    logic detect_all_channels;
    logic [2:0] detect_exceed_count;
    logic [2:0] detect_meas_length;
    logic detect_mode_enable;
  } detect_cfg_t;

  // Code n selects 2^n
  function automatic logic [7:0] pow2_code(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  // Code n selects 2^(n+1) modulator periods
  function automatic logic [CHOP_CNT_W-1:0] chop_periods(
      input logic [3:0] code);
    logic [4:0] sh;
    sh = {1'b0, code} + 5'h01;
    return {{(CHOP_CNT_W-1){1'b0}}, 1'b1} << sh;
  endfunction

  function automatic logic [15:0] pack_gain(input gain_cfg_t g);
    logic [15:0] v;
    v = 16'h0000;
    v[GAIN_CH5_LSB +: 3] = g.amp_gain_code_ch5;
    v[GAIN_CH4_LSB +: 3] = g.amp_gain_code_ch4;
    return v;
  endfunction

  function automatic logic [15:0] pack_cfg(input chop_cfg_t c,
                                           input detect_cfg_t d);
    logic [15:0] v;
    v = 16'h0000;
    v[CHOP_DLY_LSB +: 4] = c.chop_settle_delay;
    v[CHOP_EN_BIT] = c.chop_enable;
    v[DET_ALL_BIT] = d.detect_all_channels;
    v[DET_NUM_LSB +: 3] = d.detect_exceed_count;
    v[DET_LEN_LSB +: 3] = d.detect_meas_length;
    v[DET_EN_BIT] = d.detect_mode_enable;
    return v;
  endfunction
endpackage
`default_nettype wire

// File: hdl/chop_delay_timer.sv
// Settle delay timer that starts a global-chop measurement
`default_nettype none
module chop_delay_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire cfg_pkg::chop_cfg_t i_cfg,
  input wire logic i_mod_tick,
  input wire logic i_chop_start,
  output logic o_meas_start,
  output logic o_busy
);
  localparam int unsigned W = cfg_pkg::CHOP_CNT_W;

  typedef struct packed {
    logic busy;
    logic pulse;
    logic [W-1:0] cnt;
    logic [W-1:0] chk;
  } chop_state_t;

  chop_state_t s_r;
  chop_state_t s_nxt;
  logic [W-1:0] target;

  assign target = cfg_pkg::chop_periods(i_cfg.chop_settle_delay);

  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    if (!i_cfg.chop_enable) begin
      s_nxt.busy = 1'b0; // RQ9
      s_nxt.cnt = '0;
      s_nxt.chk = '0;
    end else if (i_chop_start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = '0;
      s_nxt.chk = '0;
    end else if (s_r.busy && i_mod_tick) begin
      s_nxt.chk = s_r.chk + 1'b1;
      if (s_r.cnt == target - 1'b1) begin
        s_nxt.busy = 1'b0; // RQ8
        s_nxt.pulse = 1'b1;
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_meas_start = s_r.pulse;
  assign o_busy = s_r.busy;

  property p_chop_delay_len;
    @(posedge i_clk) disable iff (i_rst)
      $rose(s_r.pulse) |-> s_r.chk == target;
  endproperty
  a_chop_delay_len: assert property (p_chop_delay_len) // RQ8
    else $error("measurement start after wrong number of periods");

  property p_chop_disabled;
    @(posedge i_clk) disable iff (i_rst)
      (!i_cfg.chop_enable && i_ce) |=> (!o_busy && !o_meas_start);
  endproperty
  a_chop_disabled: assert property (p_chop_disabled) // RQ9
    else $error("chop timer active while disabled");
endmodule
`default_nettype wire

// File: hdl/detect_counter.sv
// Current-detect exceedance counter with any/all channel combination
`default_nettype none
module detect_counter #(
  parameter int NCH = 6
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire cfg_pkg::detect_cfg_t i_cfg,
  input wire logic i_sample_valid,
  input wire logic [NCH-1:0] i_exceed,
  input wire logic i_window_restart,
  output logic o_detect,
  output logic [7:0] o_count
);
  typedef struct packed {
    logic det;
    logic [7:0] cnt;
  } det_state_t;

  det_state_t s_r;
  det_state_t s_nxt;
  logic hit;
  logic [7:0] target;
  logic [7:0] base;

  assign target = cfg_pkg::pow2_code(i_cfg.detect_exceed_count);
  assign hit = i_cfg.detect_all_channels ? &i_exceed : |i_exceed; // RQ10

  always_comb begin
    s_nxt = s_r;
    base = i_window_restart ? 8'h00 : s_r.cnt;
    if (!i_cfg.detect_mode_enable) begin
      s_nxt = '0; // RQ12
    end else begin
      if (i_window_restart) begin
        s_nxt = '0;
      end
      // A new exceedance beats a window restart in the same cycle
      if (i_sample_valid && hit && (!s_r.det || i_window_restart)) begin
        s_nxt.cnt = base + 8'h01;
        s_nxt.det = (base + 8'h01) >= target; // RQ11
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  assign o_detect = s_r.det;
  assign o_count = s_r.cnt;

  property p_det_count;
    @(posedge i_clk) disable iff (i_rst)
      $rose(o_detect) |-> o_count == target;
  endproperty
  a_det_count: assert property (p_det_count) // RQ11
    else $error("detection flagged at wrong count");

  property p_det_all;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && i_cfg.detect_all_channels && !(&i_exceed) &&
       !i_window_restart && i_cfg.detect_mode_enable) |=> $stable(o_count);
  endproperty
  a_det_all: assert property (p_det_all) // RQ10
    else $error("count moved without all channels exceeding");

  property p_det_off;
    @(posedge i_clk) disable iff (i_rst)
      (i_ce && !i_cfg.detect_mode_enable) |=> (!o_detect && o_count == 0);
  endproperty
  a_det_off: assert property (p_det_off) // RQ12
    else $error("detect active while mode disabled");
endmodule
`default_nettype wire

// File: hdl/adc_gain_chop_regs.sv
// APB register bank for channel 4/5 gain and chop/detect configuration
//
// Notes on behaviour
// (RQ1) Gain register at index 5h, resets to zero, both channels gain 1.
// (RQ2) Gain bits 6:4 pick channel 5 gain, 2^code from 1 to 128.
// (RQ3) Gain bits 2:0 pick channel 4 gain, same power-of-two mapping.
// (RQ4) Software writes zeros to gain bits 15:7.
// (RQ5) Software writes zero to gain bit 3.
// (RQ6) Config register at index 06h resets to 0600h, delay code 0011b.
// (RQ7) Software writes zeros to config bits 15:13.
// (RQ8) Bits 12:9 set 2^(n+1) modulator periods before chop measurement.
// (RQ9) Bit 8 enables global chop; when clear the delay does nothing.
// (RQ10) Bit 7 selects any channel or all channels for current detect.
// (RQ11) Bits 6:4 set 2^n exceedances needed to flag a detection.
// (RQ12) Bit 0 enables current-detect mode, reset clear.
`default_nettype none
module adc_gain_chop_regs #(
  parameter int NCH = 6
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output cfg_pkg::gain_cfg_t o_gain_cfg,
  output logic [7:0] o_gain_ch4,
  output logic [7:0] o_gain_ch5,
  output cfg_pkg::chop_cfg_t o_chop_cfg,
  output cfg_pkg::detect_cfg_t o_detect_cfg,
  input wire logic i_mod_tick,
  input wire logic i_chop_start,
  output logic o_meas_start,
  output logic o_chop_busy,
  input wire logic i_sample_valid,
  input wire logic [NCH-1:0] i_exceed,
  input wire logic i_window_restart,
  output logic o_detect,
  output logic [7:0] o_detect_count
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cfg_pkg::gain_cfg_t gain;
    cfg_pkg::chop_cfg_t chop;
    cfg_pkg::detect_cfg_t det;
    logic [7:0] g4;
    logic [7:0] g5;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic gain_fresh;
    logic cfg_fresh;
  } regs_state_t;

  function automatic cfg_pkg::gain_cfg_t unpack_gain(input logic [15:0] v);
    cfg_pkg::gain_cfg_t g;
    g.amp_gain_code_ch5 = v[cfg_pkg::GAIN_CH5_LSB +: 3];
    g.amp_gain_code_ch4 = v[cfg_pkg::GAIN_CH4_LSB +: 3];
    return g;
  endfunction

  function automatic cfg_pkg::chop_cfg_t unpack_chop(input logic [15:0] v);
    cfg_pkg::chop_cfg_t c;
    c.chop_settle_delay = v[cfg_pkg::CHOP_DLY_LSB +: 4];
    c.chop_enable = v[cfg_pkg::CHOP_EN_BIT];
    return c;
  endfunction

  function automatic cfg_pkg::detect_cfg_t unpack_det(input logic [15:0] v);
    cfg_pkg::detect_cfg_t d;
    d.detect_all_channels = v[cfg_pkg::DET_ALL_BIT];
    d.detect_exceed_count = v[cfg_pkg::DET_NUM_LSB +: 3];
    d.detect_meas_length = v[cfg_pkg::DET_LEN_LSB +: 3];
    d.detect_mode_enable = v[cfg_pkg::DET_EN_BIT];
    return d;
  endfunction

  // Byte-lane merge of a 16-bit register image
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0] strb);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  localparam cfg_pkg::gain_cfg_t GAIN_RST = unpack_gain(cfg_pkg::GAIN_RESET);
  localparam cfg_pkg::chop_cfg_t CHOP_RST = unpack_chop(cfg_pkg::CFG_RESET);
  localparam cfg_pkg::detect_cfg_t DET_RST = unpack_det(cfg_pkg::CFG_RESET);

  localparam regs_state_t RESET_STATE = '{
    gain: GAIN_RST,
    chop: CHOP_RST,
    det: DET_RST,
    g4: cfg_pkg::pow2_code(GAIN_RST.amp_gain_code_ch4),
    g5: cfg_pkg::pow2_code(GAIN_RST.amp_gain_code_ch5),
    rdata: 32'h0000_0000,
    ready: 1'b0,
    slverr: 1'b0,
    gain_fresh: 1'b1,
    cfg_fresh: 1'b1
  };

  regs_state_t s_r;
  regs_state_t s_nxt;

  logic setup;
  logic access;
  logic sel_gain;
  logic sel_cfg;
  logic [15:0] gain_img;
  logic [15:0] cfg_img;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable && s_r.ready;
  assign sel_gain = i_paddr == cfg_pkg::ADDR_GAIN;
  assign sel_cfg = i_paddr == cfg_pkg::ADDR_CFG;
  assign gain_img = cfg_pkg::pack_gain(s_r.gain);
  assign cfg_img = cfg_pkg::pack_cfg(s_r.chop, s_r.det);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    if (setup) begin
      // Answer is prepared in setup so pready is high in the access phase
      s_nxt.ready = 1'b1;
      s_nxt.slverr = !(sel_gain || sel_cfg);
      if (sel_gain) begin
        s_nxt.rdata = {16'h0000, gain_img}; // RQ1
      end else if (sel_cfg) begin
        s_nxt.rdata = {16'h0000, cfg_img}; // RQ6
      end else begin
        s_nxt.rdata = 32'h0000_0000;
      end
    end
    if (access && i_pwrite && sel_gain) begin
      // Reserved bits are not stored and read back as zero
      s_nxt.gain = unpack_gain(
          merge16(gain_img, i_pwdata[15:0], i_pstrb[1:0])); // RQ2 RQ3
      s_nxt.gain_fresh = 1'b0;
    end
    if (access && i_pwrite && sel_cfg) begin
      s_nxt.chop = unpack_chop(
          merge16(cfg_img, i_pwdata[15:0], i_pstrb[1:0])); // RQ8 RQ9
      s_nxt.det = unpack_det(
          merge16(cfg_img, i_pwdata[15:0], i_pstrb[1:0])); // RQ10 RQ12
      s_nxt.cfg_fresh = 1'b0;
    end
    s_nxt.g4 = cfg_pkg::pow2_code(s_nxt.gain.amp_gain_code_ch4); // RQ3
    s_nxt.g5 = cfg_pkg::pow2_code(s_nxt.gain.amp_gain_code_ch5); // RQ2
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= RESET_STATE;
    end else if (i_ce) begin
      s_r <= s_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_prdata = s_r.rdata;
  assign o_pready = s_r.ready;
  assign o_pslverr = s_r.slverr;
  assign o_gain_cfg = s_r.gain;
  assign o_gain_ch4 = s_r.g4;
  assign o_gain_ch5 = s_r.g5;
  assign o_chop_cfg = s_r.chop;
  assign o_detect_cfg = s_r.det;

  // ---------------------------------------------------------------
  // Chop delay and current detect
  // ---------------------------------------------------------------
  chop_delay_timer u_chop (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cfg(s_r.chop),
    .i_mod_tick(i_mod_tick),
    .i_chop_start(i_chop_start),
    .o_meas_start(o_meas_start),
    .o_busy(o_chop_busy)
  );

  detect_counter #(
    .NCH(NCH)
  ) u_detect (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cfg(s_r.det),
    .i_sample_valid(i_sample_valid),
    .i_exceed(i_exceed),
    .i_window_restart(i_window_restart),
    .o_detect(o_detect),
    .o_count(o_detect_count)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_gain_write;
    access && i_pwrite && sel_gain && i_ce;
  endsequence

  sequence s_cfg_write;
    access && i_pwrite && sel_cfg && i_ce && i_pstrb[1:0] == 2'b11;
  endsequence

  property p_gain_reset;
    @(posedge i_clk) disable iff (i_rst)
      s_r.gain_fresh |-> (gain_img == cfg_pkg::GAIN_RESET &&
                          o_gain_ch4 == 8'h01 && o_gain_ch5 == 8'h01);
  endproperty
  a_gain_reset: assert property (p_gain_reset) // RQ1
    else $error("gain register not at reset value");

  property p_gain_ch5;
    @(posedge i_clk) disable iff (i_rst)
      (s_gain_write and i_pstrb[0]) |=>
        o_gain_ch5 == (8'h01 << $past(i_pwdata[6:4]));
  endproperty
  a_gain_ch5: assert property (p_gain_ch5) // RQ2
    else $error("channel 5 gain does not follow write");

  property p_gain_ch4;
    @(posedge i_clk) disable iff (i_rst)
      (s_gain_write and i_pstrb[0]) |=>
        o_gain_ch4 == (8'h01 << $past(i_pwdata[2:0]));
  endproperty
  a_gain_ch4: assert property (p_gain_ch4) // RQ3
    else $error("channel 4 gain does not follow write");

  property p_cfg_reset;
    @(posedge i_clk) disable iff (i_rst)
      s_r.cfg_fresh |-> (cfg_img == cfg_pkg::CFG_RESET &&
                         o_chop_cfg.chop_settle_delay == 4'h3);
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) // RQ6
    else $error("config register not at reset value");

  property p_cfg_fields;
    @(posedge i_clk) disable iff (i_rst)
      s_cfg_write |=>
        (o_chop_cfg.chop_settle_delay == $past(i_pwdata[12:9]) &&
         o_chop_cfg.chop_enable == $past(i_pwdata[8]) &&
         o_detect_cfg.detect_all_channels == $past(i_pwdata[7]) &&
         o_detect_cfg.detect_exceed_count == $past(i_pwdata[6:4]) &&
         o_detect_cfg.detect_mode_enable == $past(i_pwdata[0]));
  endproperty
  a_cfg_fields: assert property (p_cfg_fields) // RQ8 RQ9 RQ10 RQ12
    else $error("config fields do not follow write");

  property p_read_back;
    @(posedge i_clk) disable iff (i_rst)
      (setup && i_ce && sel_cfg) |=>
        (o_pready && !o_pslverr && o_prdata == {16'h0000, cfg_img});
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("config read data wrong");

  property p_unmapped;
    @(posedge i_clk) disable iff (i_rst)
      (setup && i_ce && !sel_gain && !sel_cfg) |=>
        (o_pready && o_pslverr && o_prdata == 32'h0000_0000);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  property p_gain_read;
    @(posedge i_clk) disable iff (i_rst)
      (setup && i_ce && sel_gain) |=>
        (o_pready && !o_pslverr && o_prdata == {16'h0000, gain_img});
  endproperty
  a_gain_read: assert property (p_gain_read) // RQ1
    else $error("gain read data wrong");

  // Zero wait states: ready stands for the first access cycle only
  property p_ready_pulse;
    @(posedge i_clk) disable iff (i_rst)
      (o_pready && i_ce) |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
endmodule
`default_nettype wire

// File: testbench/adc_gain_and_chop_config_regs_tb_top.sv
// Self-checking bench for the gain and chop/detect register bank
`default_nettype none
module adc_gain_and_chop_config_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic i_mod_tick = 1'b0;
  logic i_chop_start = 1'b0;
  logic i_sample_valid = 1'b0;
  logic [5:0] i_exceed = 6'h00;
  logic i_window_restart = 1'b0;
  logic [31:0] o_prdata;
  logic o_pready;
  logic o_pslverr;
  cfg_pkg::gain_cfg_t o_gain_cfg;
  logic [7:0] o_gain_ch4;
  logic [7:0] o_gain_ch5;
  cfg_pkg::chop_cfg_t o_chop_cfg;
  cfg_pkg::detect_cfg_t o_detect_cfg;
  logic o_meas_start;
  logic o_chop_busy;
  logic o_detect;
  logic [7:0] o_detect_count;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int checked = 0;

  always #2.5 i_clk = ~i_clk;

  adc_gain_chop_regs #(.NCH(6)) adc_gain_chop_regs_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(4'hf),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_gain_cfg(o_gain_cfg), .o_gain_ch4(o_gain_ch4),
    .o_gain_ch5(o_gain_ch5), .o_chop_cfg(o_chop_cfg),
    .o_detect_cfg(o_detect_cfg), .i_mod_tick(i_mod_tick),
    .i_chop_start(i_chop_start), .o_meas_start(o_meas_start),
    .o_chop_busy(o_chop_busy), .i_sample_valid(i_sample_valid),
    .i_exceed(i_exceed), .i_window_restart(i_window_restart),
    .o_detect(o_detect), .o_detect_count(o_detect_count)
  );

  // ------------------------------------------------------------
  // Reporting
  // ------------------------------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // APB master
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // Read right after the edge: values are those that edge sampled
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: no ready answer", $time);
      stop_test();
    end
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic do_reset;
    @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    chk(32'(o_gain_ch4), 32'h01, "ch4 gain at reset");
    chk(32'(o_gain_ch5), 32'h01, "ch5 gain at reset");
    chk(32'(o_chop_cfg), 32'h06, "chop fields at reset");
    chk(32'(o_detect_cfg), 32'h00, "detect fields at reset");
    apb(1'b0, cfg_pkg::ADDR_GAIN, 32'h0, rd, er);
    chk(rd, 32'h0000_0000, "gain reset read");
    apb(1'b0, cfg_pkg::ADDR_CFG, 32'h0, rd, er);
    chk(rd, 32'h0000_0600, "config reset read");
  endtask

  task automatic gain_test;
    logic [2:0] c;
    for (int k = 0; k < 8; k++) begin
      c = 3'(k);
      apb(1'b1, cfg_pkg::ADDR_GAIN, {25'h0, c, 1'b0, ~c}, rd, er);
      @(negedge i_clk);
      chk(32'(o_gain_ch5), 32'h1 << k, "ch5 gain");
      chk(32'(o_gain_ch4), 32'h1 << (7 - k), "ch4 gain");
      chk(32'(o_gain_cfg), {26'h0, c, ~c}, "gain codes");
      apb(1'b0, cfg_pkg::ADDR_GAIN, 32'h0, rd, er);
      chk(rd, {25'h0, c, 1'b0, ~c}, "gain read back");
    end
  endtask

  task automatic unmapped_test;
    apb(1'b1, 12'h01c, 32'h0000_0777, rd, er);
    chk(32'(er), 32'h1, "unmapped write error");
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk(32'(er), 32'h1, "unmapped read error");
    chk(rd, 32'h0, "unmapped read data");
    apb(1'b0, cfg_pkg::ADDR_GAIN, 32'h0, rd, er);
    chk(rd, 32'h0000_0070, "gain kept");
  endtask

  task automatic chop_case(input logic [3:0] n);
    int t;
    t = 2 << n;
    apb(1'b1, cfg_pkg::ADDR_CFG, {19'h0, n, 1'b1, 8'h00}, rd, er);
    i_chop_start <= 1'b1;
    @(posedge i_clk);
    i_chop_start <= 1'b0;
    @(negedge i_clk);
    chk(32'(o_chop_cfg), {27'h0, n, 1'b1}, "chop fields");
    chk(32'(o_chop_busy), 32'h1, "busy after start");
    for (int k = 0; k < t; k++) begin
      @(posedge i_clk);
      i_mod_tick <= 1'b1;
      @(negedge i_clk);
      chk(32'(o_meas_start), 32'h0, "early start");
    end
    @(posedge i_clk);
    i_mod_tick <= 1'b0;
    @(negedge i_clk);
    chk(32'(o_meas_start), 32'h1, "measurement start");
    chk(32'(o_chop_busy), 32'h0, "busy after delay");
    @(negedge i_clk);
    chk(32'(o_meas_start), 32'h0, "start pulse width");
  endtask

  task automatic chop_off;
    apb(1'b1, cfg_pkg::ADDR_CFG, 32'h0000_0000, rd, er);
    i_chop_start <= 1'b1;
    @(posedge i_clk);
    i_chop_start <= 1'b0;
    i_mod_tick <= 1'b1;
    repeat (4) begin
      @(negedge i_clk);
      chk(32'(o_chop_busy), 32'h0, "busy while disabled");
      chk(32'(o_meas_start), 32'h0, "start while disabled");
    end
    @(posedge i_clk);
    i_mod_tick <= 1'b0;
  endtask

  task automatic det_case(input logic all, input logic [2:0] code,
                          input logic [5:0] bad, input logic [5:0] good);
    int need;
    need = 1 << code;
    apb(1'b1, cfg_pkg::ADDR_CFG, {24'h0, all, code, code, 1'b1}, rd,
        er);
    apb(1'b0, cfg_pkg::ADDR_CFG, 32'h0, rd, er);
    chk(rd, {24'h0, all, code, code, 1'b1},
        "config read back");
    chk(32'(o_detect_cfg), {24'h0, all, code, code, 1'b1},
        "detect fields");
    i_window_restart <= 1'b1;
    @(posedge i_clk);
    i_window_restart <= 1'b0;
    i_sample_valid <= 1'b1;
    i_exceed <= bad;
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    @(negedge i_clk);
    chk(32'(o_detect_count), 32'h0, "miss counted");
    for (int k = 1; k <= need; k++) begin
      @(posedge i_clk);
      i_sample_valid <= 1'b1;
      i_exceed <= good;
      @(posedge i_clk);
      i_sample_valid <= 1'b0;
      @(negedge i_clk);
      chk(32'(o_detect_count), 32'(k), "hit count");
      chk(32'(o_detect), 32'(k == need), "detect flag");
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    do_reset();
    gain_test();
    unmapped_test();
    chop_case(4'h0);
    chop_case(4'h2);
    chop_off();
    det_case(1'b0, 3'h0, 6'h00, 6'h20);
    det_case(1'b1, 3'h2, 6'h1f, 6'h3f);
    det_case(1'b0, 3'h7, 6'h00, 6'h01);
    apb(1'b1, cfg_pkg::ADDR_CFG, 32'h0000_0000, rd, er);
    // Mode takes effect at the write edge, the counter clears one later
    repeat (2) @(negedge i_clk);
    chk(32'(o_detect), 32'h0, "detect after disable");
    chk(32'(o_detect_count), 32'h0, "count after disable");
    do_reset();
    stop_test();
  end
endmodule
`default_nettype wire
